//--- core/csm_regs.vh
// Constants for the cache storage monitor control block.
// Assumes a simple per-page register port and a 10 MHz clock.
//
// Behaviour
// - Secure and non-secure capture triggers are separate; secure may also reach non-secure.
// - Capture trigger sits at 0x0808 in each page, write-only, reads zero.
// - Control accesses go to the monitor picked by instance and monitor select.
// - Without monitoring support the control location reads zero, ignores writes.
// - Enable bit 31 clear stops collection; set collects per configuration.
// - Capture source bits 30:28: none, external events one to six, or trigger.
// - An omitted optional event source never causes a capture.
// - Without capture support, capture source and clear-after-snapshot read zero, ignore writes.
// - Clear-after-snapshot bit 27 zeroes the value right after the snapshot.
// - Wrap flag bit 26 sets on overflow and holds until written zero.
// - With capture-as-wrap or linkage, a usage-value store clears a set wrap flag.
// - If overflow is impossible, wrap flag and hold-on-wrap read zero, ignore writes.
// - Wrap interrupt enable bit 25 raises an interrupt on overflow; else read zero.
// - Hold-on-wrap bit 24: clear wraps, set freezes the value.
// - A frozen value stays until software writes the usage value.
// - Snapshot-on-wrap bit 23 snapshots value and not-ready on overflow.
// - After an overflow snapshot, hold stops counting and clear zeroes.
// - Subtype bits 22:20 read zero and ignore writes.
// - Capture-as-wrap bit 18: capture snapshots, applies wrap behaviour, sets wrap flag.
// - Group filter enable bit 17 restricts measurement to the filter group.
// - Group on, partition off: behaves as if partition filtering were on.
// - Trigger write with bit 0 set signals capture to source-7 monitors.
// - Partition filter enable bit 16 restricts measurement to the filter partition.
`ifndef CSM_REGS_VH
`define CSM_REGS_VH

// ==========================================================
// Register offsets within each security-state page
`define CSM_OFF_MON_SEL 12'h800
`define CSM_OFF_CAPT_TRIG 12'h808
`define CSM_OFF_CTL 12'h818
`define CSM_OFF_VALUE 12'h840
`define CSM_OFF_SNAP 12'h848

// ==========================================================
// Control register fields
`define CSM_EN_BIT 31
`define CSM_SRC_HI 30
`define CSM_SRC_LO 28
`define CSM_CLR_BIT 27
`define CSM_WFLAG_BIT 26
`define CSM_IRQEN_BIT 25
`define CSM_HOLD_BIT 24
`define CSM_SNAPW_BIT 23
`define CSM_CEVNT_BIT 18
`define CSM_GRP_BIT 17
`define CSM_PART_BIT 16
`define CSM_SRC_TRIGGER 3'h7
`define CSM_SRC_NONE 3'h0

// ==========================================================
// Capture trigger and monitor select fields
`define CSM_TRIG_NOW_BIT 0
`define CSM_TRIG_ALL_BIT 1
`define CSM_SEL_MON_BIT 0
`define CSM_SEL_RIS_HI 31
`define CSM_SEL_RIS_LO 24

// ==========================================================
// Reset values and usage value layout
`define CSM_CTL_RST 32'h0000_0000
`define CSM_SEL_RST 32'h0000_0000
`define CSM_NOT_READY_FLAG_BIT 31
`define CSM_VAL_W 31

`endif

//--- core/csm_usage_value.v
// One monitor's usage value with wrap, freeze, clear and snapshot handling.
// Assumes the increment is already filtered and gated by the enable.
`timescale 1ns/100ps
`include "csm_regs.vh"

module csm_usage_value (
  input wire clk,
  input wire resetn,
  input wire [7:0] inc,
  input wire capture,
  input wire cap_as_wrap,
  input wire clear_after_snapshot,
  input wire hold_on_wrap,
  input wire snapshot_on_wrap,
  input wire sw_write,
  input wire [31:0] sw_data,
  input wire not_ready_flag,
  output reg [30:0] value_q,
  output reg [31:0] snap_q,
  output reg wrap_pulse_q
);

  reg frozen_q;
  reg [30:0] value_d;
  wire [7:0] inc_eff;
  wire [31:0] sum;
  wire wrap;
  wire treat_wrap;
  wire snap_now;
  wire clear;

  assign inc_eff = frozen_q ? 8'h00 : inc;
  assign sum = {1'b0, value_q} + {24'h000000, inc_eff};
  assign wrap = sum[`CSM_VAL_W];
  assign treat_wrap = wrap | (capture & cap_as_wrap);
  assign snap_now = capture | (wrap & snapshot_on_wrap);
  assign clear = snap_now & clear_after_snapshot;

  // ==========================================================
  // Next value
  always @*
  begin
    if (treat_wrap && hold_on_wrap)
    begin
      if (clear)
        value_d = 31'h00000000;
      else if (wrap)
        value_d = sum[30:0];
      else
        value_d = value_q;
    end
    else if (clear)
      value_d = capture ? {23'h000000, inc_eff} : 31'h00000000;
    else
      value_d = sum[30:0];
  end

  // ==========================================================
  // State
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      value_q <= 31'h00000000;
      snap_q <= 32'h00000000;
      frozen_q <= 1'b0;
      wrap_pulse_q <= 1'b0;
    end
    else
    begin
      wrap_pulse_q <= treat_wrap;
      if (snap_now)
        snap_q <= {not_ready_flag, capture ? value_q : sum[30:0]};
      if (sw_write)
      begin
        value_q <= sw_data[30:0];
        frozen_q <= 1'b0;
      end
      else
      begin
        value_q <= value_d;
        if (treat_wrap && hold_on_wrap)
          frozen_q <= 1'b1;
      end
    end
  end

endmodule // csm_usage_value

//--- core/csm_ctrl.v
// Control for four cache storage usage monitors, two per security state.
// Assumes a simple per-page register port, allocation events and filter values
// supplied from logic on the same clock, and external capture pins from elsewhere.
`timescale 1ns/100ps
`include "csm_regs.vh"

module csm_ctrl #(
  parameter HAS_MONITOR = 1,
  parameter HAS_CAPTURE = 1,
  parameter HAS_TRIGGER_ACTS_AS_WRAP = 1,
  parameter HAS_SNAPSHOT_ON_WRAP = 1,
  parameter HAS_WRAP_IRQ_EN = 1,
  parameter CAN_OVERFLOW = 1,
  parameter WRAP_LINK_SUPPORTED = 0,
  parameter INSTANCE_SEL_SUPPORTED = 1,
  parameter [5:0] EXT_EVT_PRESENT = 6'h3f
) (
  input wire clk,
  input wire resetn,
  input wire reg_req,
  input wire reg_wr,
  input wire reg_ns,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_q,
  output reg reg_ack_q,
  input wire [5:0] ext_capture,
  input wire alloc_valid,
  input wire [15:0] alloc_partition_id,
  input wire [7:0] alloc_monitoring_group,
  input wire [7:0] alloc_bytes,
  input wire [63:0] filt_partition_id,
  input wire [31:0] filt_monitoring_group,
  input wire [3:0] not_ready_flag,
  output reg [3:0] wrap_irq_q
);

  // ==========================================================
  // Helpers
  function filter_match;
    input part_en;
    input grp_en;
    input [15:0] pid;
    input [7:0] grp;
    input [15:0] fpid;
    input [7:0] fgrp;
    begin
      // Group-only filtering also matches the partition
      filter_match = (!(part_en | grp_en) || (pid == fpid)) &&
                     (!grp_en || (grp == fgrp));
    end
  endfunction

  function [31:0] ctl_mask;
    input dummy;
    reg [31:0] m;
    begin
      m = 32'h0000_0000;
      m[`CSM_EN_BIT] = 1'b1;
      m[`CSM_GRP_BIT] = 1'b1;
      m[`CSM_PART_BIT] = 1'b1;
      if (HAS_CAPTURE != 0)
      begin
        m[`CSM_SRC_HI:`CSM_SRC_LO] = 3'h7;
        m[`CSM_CLR_BIT] = 1'b1;
      end
      if (CAN_OVERFLOW != 0)
      begin
        m[`CSM_WFLAG_BIT] = 1'b1;
        m[`CSM_HOLD_BIT] = 1'b1;
      end
      if (HAS_WRAP_IRQ_EN != 0)
        m[`CSM_IRQEN_BIT] = 1'b1;
      if (HAS_SNAPSHOT_ON_WRAP != 0)
        m[`CSM_SNAPW_BIT] = 1'b1;
      if (HAS_TRIGGER_ACTS_AS_WRAP != 0)
        m[`CSM_CEVNT_BIT] = 1'b1;
      ctl_mask = m;
    end
  endfunction

  localparam [31:0] CTL_MASK = ctl_mask(1'b0);
  localparam STORE_CLEARS_FLAG = (HAS_TRIGGER_ACTS_AS_WRAP != 0) || (WRAP_LINK_SUPPORTED != 0);

  // ==========================================================
  // Storage
  reg [31:0] ctl_q [0:3];
  reg [31:0] sel_q [0:1];
  reg [5:0] ext_meta_q;
  reg [5:0] ext_sync_q;
  reg [5:0] ext_prev_q;
  reg trig_s_q;
  reg trig_all_q;
  reg trig_ns_q;

  wire [30:0] value [0:3];
  wire [31:0] snap [0:3];
  wire [3:0] wrap_pulse;
  wire [3:0] capture;
  wire [3:0] value_wr;
  wire [5:0] ext_rise;

  // ==========================================================
  // Access decode
  wire page_sel_ok;
  wire [1:0] tgt;
  wire acc;
  wire wr;
  wire ctl_hit;

  assign page_sel_ok = (INSTANCE_SEL_SUPPORTED == 0) ||
                       (sel_q[reg_ns][`CSM_SEL_RIS_HI:`CSM_SEL_RIS_LO] == 8'h00);
  assign tgt = {reg_ns, sel_q[reg_ns][`CSM_SEL_MON_BIT]};
  assign acc = reg_req && (HAS_MONITOR != 0) && !reg_ack_q;
  assign wr = acc && reg_wr;
  assign ctl_hit = (reg_addr == `CSM_OFF_CTL) && page_sel_ok;
  assign ext_rise = ext_sync_q & ~ext_prev_q;

  // ==========================================================
  // External capture pins, two flops then edge detect
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_meta_q <= 6'h00;
      ext_sync_q <= 6'h00;
      ext_prev_q <= 6'h00;
    end
    else
    begin
      ext_meta_q <= ext_capture;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // ==========================================================
  // Capture trigger writes
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trig_s_q <= 1'b0;
      trig_all_q <= 1'b0;
      trig_ns_q <= 1'b0;
    end
    else
    begin
      trig_s_q <= wr && !reg_ns && (reg_addr == `CSM_OFF_CAPT_TRIG) &&
                  reg_wdata[`CSM_TRIG_NOW_BIT];
      trig_all_q <= reg_wdata[`CSM_TRIG_ALL_BIT] && !reg_ns;
      trig_ns_q <= wr && reg_ns && (reg_addr == `CSM_OFF_CAPT_TRIG) &&
                   reg_wdata[`CSM_TRIG_NOW_BIT];
    end
  end

  // ==========================================================
  // Per-monitor capture, filtering and value
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : mon
      wire [2:0] src;
      wire ext_hit;
      wire trig_hit;
      wire match;
      wire [7:0] inc;

      assign src = ctl_q[g][`CSM_SRC_HI:`CSM_SRC_LO];
      assign ext_hit = (src != `CSM_SRC_NONE) && (src != `CSM_SRC_TRIGGER) &&
                       EXT_EVT_PRESENT[src - 3'h1] && ext_rise[src - 3'h1];
      // Bit 1 of the index is the page: 0 secure, 1 non-secure
      assign trig_hit = (src == `CSM_SRC_TRIGGER) &&
                        ((g < 2) ? trig_s_q : (trig_ns_q || (trig_s_q && trig_all_q)));
      assign capture[g] = (HAS_CAPTURE != 0) && (ext_hit || trig_hit);
      assign match = filter_match(ctl_q[g][`CSM_PART_BIT], ctl_q[g][`CSM_GRP_BIT],
                                  alloc_partition_id, alloc_monitoring_group,
                                  filt_partition_id[g*16 +: 16], filt_monitoring_group[g*8 +: 8]);
      assign inc = (alloc_valid && match && ctl_q[g][`CSM_EN_BIT]) ? alloc_bytes : 8'h00;
      assign value_wr[g] = wr && (reg_addr == `CSM_OFF_VALUE) && page_sel_ok && (tgt == g);

      csm_usage_value csm_usage_value_inst (
        .clk(clk),
        .resetn(resetn),
        .inc(inc),
        .capture(capture[g]),
        .cap_as_wrap(ctl_q[g][`CSM_CEVNT_BIT]),
        .clear_after_snapshot(ctl_q[g][`CSM_CLR_BIT]),
        .hold_on_wrap(ctl_q[g][`CSM_HOLD_BIT]),
        .snapshot_on_wrap(ctl_q[g][`CSM_SNAPW_BIT]),
        .sw_write(value_wr[g]),
        .sw_data(reg_wdata),
        .not_ready_flag(not_ready_flag[g]),
        .value_q(value[g]),
        .snap_q(snap[g]),
        .wrap_pulse_q(wrap_pulse[g])
      );
    end
  endgenerate

  // ==========================================================
  // Control and select registers, wrap flag
  integer i;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (i = 0; i < 4; i = i + 1)
        ctl_q[i] <= `CSM_CTL_RST;
      sel_q[0] <= `CSM_SEL_RST;
      sel_q[1] <= `CSM_SEL_RST;
      wrap_irq_q <= 4'h0;
    end
    else
    begin
      if (wr && (reg_addr == `CSM_OFF_MON_SEL))
      begin
        sel_q[reg_ns][`CSM_SEL_MON_BIT] <= reg_wdata[`CSM_SEL_MON_BIT];
        if (INSTANCE_SEL_SUPPORTED != 0)
          sel_q[reg_ns][`CSM_SEL_RIS_HI:`CSM_SEL_RIS_LO] <= reg_wdata[`CSM_SEL_RIS_HI:`CSM_SEL_RIS_LO];
      end
      for (i = 0; i < 4; i = i + 1)
      begin
        if (wr && ctl_hit && (tgt == i))
          ctl_q[i] <= reg_wdata & CTL_MASK;
        else if (STORE_CLEARS_FLAG && value_wr[i])
          ctl_q[i][`CSM_WFLAG_BIT] <= 1'b0;
        // Hardware set wins over any clear in the same cycle
        if (wrap_pulse[i] && (CAN_OVERFLOW != 0))
          ctl_q[i][`CSM_WFLAG_BIT] <= 1'b1;
        wrap_irq_q[i] <= wrap_pulse[i] && ctl_q[i][`CSM_IRQEN_BIT];
      end
    end
  end

  // ==========================================================
  // Read path and acknowledge
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata_q <= 32'h0000_0000;
      reg_ack_q <= 1'b0;
    end
    else
    begin
      reg_ack_q <= reg_req && !reg_ack_q;
      reg_rdata_q <= 32'h0000_0000;
      if (acc && !reg_wr)
      begin
        case (reg_addr)
          `CSM_OFF_MON_SEL: reg_rdata_q <= sel_q[reg_ns];
          `CSM_OFF_CTL: reg_rdata_q <= page_sel_ok ? ctl_q[tgt] : 32'h0000_0000;
          `CSM_OFF_VALUE: reg_rdata_q <= page_sel_ok ? {not_ready_flag[tgt], value[tgt]} : 32'h0000_0000;
          `CSM_OFF_SNAP: reg_rdata_q <= page_sel_ok ? snap[tgt] : 32'h0000_0000;
          default: reg_rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // csm_ctrl

//--- bench/csm_ctrl_sva.sv
// Checker for the storage monitor control register port.
// Assumes it is bound to csm_ctrl and sees only its ports.
`timescale 1ns/100ps
module csm_ctrl_sva (
  input wire clk,
  input wire resetn,
  input wire reg_req,
  input wire reg_wr,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata_q,
  input wire reg_ack_q,
  input wire [3:0] wrap_irq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Helper: an interrupt enable was ever written
  reg irq_en_q;
  wire take = reg_req && !reg_ack_q;
  wire rd = take && !reg_wr;
  always @(posedge clk or negedge resetn)
    if (!resetn)
      irq_en_q <= 1'b0;
    else if (take && reg_wr && reg_addr == 12'h818 && reg_wdata[25])
      irq_en_q <= 1'b1;
  // ==========================================================
  // Properties
  property p_ack; take |=> reg_ack_q; endproperty
  property p_pulse; reg_ack_q |=> !reg_ack_q; endproperty
  property p_cause; reg_ack_q |-> $past(reg_req); endproperty
  property p_idle; !reg_ack_q |-> reg_rdata_q == 32'h0; endproperty
  property p_trig; rd && reg_addr == 12'h808 |=> reg_rdata_q == 32'h0; endproperty
  property p_subtype; rd && reg_addr == 12'h818 |=> reg_rdata_q[22:19] == 4'h0; endproperty
  property p_unmap; rd && reg_addr == 12'h900 |=> reg_rdata_q == 32'h0; endproperty
  property p_irq; |wrap_irq_q |-> irq_en_q; endproperty
  a_ack: assert property (p_ack) else $error("no answer to request");
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_idle: assert property (p_idle) else $error("read data outside answer");
  a_trig: assert property (p_trig) else $error("trigger register read nonzero");
  a_subtype: assert property (p_subtype) else $error("subtype bits nonzero");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  a_irq: assert property (p_irq) else $error("interrupt without enable");
  c_irq: cover property (|wrap_irq_q);
  c_trig: cover property (take && reg_wr && reg_addr == 12'h808 && reg_wdata[0]);
  c_ctl: cover property (rd && reg_addr == 12'h818);
endmodule // csm_ctrl_sva

bind csm_ctrl csm_ctrl_sva csm_ctrl_sva_inst (.clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
  .wrap_irq_q(wrap_irq_q));

//--- bench/tb_top.sv
// Self-checking bench for the storage monitor control block.
// Assumes csm_ctrl with default parameters and the bound checker.
`timescale 1ns/100ps
module tb_top;
  logic clk, resetn, reg_req, reg_wr, reg_ns, reg_ack_q, alloc_valid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, rd, filt_monitoring_group;
  logic [5:0] ext_capture;
  logic [15:0] alloc_partition_id;
  logic [7:0] alloc_monitoring_group, alloc_bytes;
  logic [63:0] filt_partition_id;
  logic [3:0] wrap_irq_q, not_ready_flag;
  int miscompares, comparisons, irqs;
  typedef struct {logic wr; logic ns; logic [11:0] a; logic [31:0] d;} csm_row_t;
  // Reads carry the expected data in d
  csm_row_t rows[12] = '{'{1, 0, 12'h800, 32'h0}, '{1, 0, 12'h818, 32'hfbff_ffff},
    '{0, 0, 12'h818, 32'hfb87_0000}, '{0, 0, 12'h808, 32'h0}, '{0, 1, 12'h818, 32'h0},
    '{1, 1, 12'h808, 32'h3}, '{1, 0, 12'h800, 32'h1}, '{0, 0, 12'h818, 32'h0},
    '{1, 0, 12'h800, 32'h0100_0000}, '{0, 0, 12'h818, 32'h0}, '{1, 0, 12'h800, 32'h0},
    '{0, 0, 12'h900, 32'h0}};

  csm_ctrl csm_ctrl_inst (.clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_wr(reg_wr), .reg_ns(reg_ns),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
    .ext_capture(ext_capture), .alloc_valid(alloc_valid), .alloc_partition_id(alloc_partition_id),
    .alloc_monitoring_group(alloc_monitoring_group), .alloc_bytes(alloc_bytes),
    .filt_partition_id(filt_partition_id), .filt_monitoring_group(filt_monitoring_group),
    .not_ready_flag(not_ready_flag), .wrap_irq_q(wrap_irq_q));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(negedge clk)
    if ((|wrap_irq_q) === 1'b1)
      irqs++;

  task chk(input [31:0] got, input [31:0] exp);
  begin
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task acc(input logic w, input logic n, input [11:0] a, input [31:0] d);
    int k;
  begin
    @(posedge clk);
    #10;
    reg_req = 1'b1;
    reg_wr = w;
    reg_ns = n;
    reg_addr = a;
    reg_wdata = d;
    k = 0;
    do
    begin
      @(posedge clk);
      #10;
      k++;
    end
    while (reg_ack_q !== 1'b1 && k < 8);
    chk({31'h0, reg_ack_q}, 32'h1);
    rd = reg_rdata_q;
    reg_req = 1'b0;
  end
  endtask

  task alloc(input [15:0] p, input [7:0] g, input [7:0] b);
  begin
    @(posedge clk);
    #10;
    alloc_partition_id = p;
    alloc_monitoring_group = g;
    alloc_bytes = b;
    alloc_valid = 1'b1;
    @(posedge clk);
    #10;
    alloc_valid = 1'b0;
  end
  endtask

  task end_of_test;
  begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  initial
  begin
    #500000;
    miscompares++;
    end_of_test;
  end

  initial
  begin
    {resetn, reg_req, reg_wr, reg_ns, alloc_valid} = 5'h0;
    {reg_addr, reg_wdata, ext_capture, alloc_partition_id} = 66'h0;
    {alloc_monitoring_group, alloc_bytes, filt_partition_id, filt_monitoring_group} = 112'h0;
    not_ready_flag = 4'h0;
    repeat (10) @(posedge clk);
    #10;
    resetn = 1'b1;
    foreach (rows[i])
    begin
      acc(rows[i].wr, rows[i].ns, rows[i].a, rows[i].d);
      if (!rows[i].wr)
        chk(rd, rows[i].d);
    end
    // ==========================================================
    // Overflow with freeze and interrupt
    acc(1, 0, 12'h818, 32'h8300_0000);
    acc(1, 0, 12'h840, 32'h7fff_fff0);
    irqs = 0;
    alloc(16'h0, 8'h0, 8'h20);
    repeat (4) @(posedge clk);
    chk(irqs, 1);
    acc(0, 0, 12'h818, 32'h0);
    chk(rd, 32'h8700_0000);
    alloc(16'h0, 8'h0, 8'h05);
    acc(0, 0, 12'h840, 32'h0);
    chk(rd, 32'h10);
    acc(1, 0, 12'h840, 32'h5);
    acc(0, 0, 12'h818, 32'h0);
    chk(rd, 32'h8300_0000);
    alloc(16'h0, 8'h0, 8'h03);
    acc(0, 0, 12'h840, 32'h0);
    chk(rd, 32'h8);
    // ==========================================================
    // Software trigger with clear after snapshot
    acc(1, 0, 12'h818, 32'hf800_0000);
    acc(1, 0, 12'h808, 32'h0);
    acc(1, 1, 12'h808, 32'h1);
    acc(0, 0, 12'h848, 32'h0);
    chk(rd, 32'h0);
    acc(1, 0, 12'h808, 32'h1);
    acc(0, 0, 12'h848, 32'h0);
    chk(rd, 32'h8);
    acc(0, 0, 12'h840, 32'h0);
    chk(rd, 32'h0);
    // ==========================================================
    // External capture sources one to six
    for (int e = 1; e <= 6; e++)
    begin
      acc(1, 0, 12'h818, {1'b1, e[2:0], 28'h0});
      acc(1, 0, 12'h840, 32'(e));
      ext_capture[e-1] = 1'b1;
      repeat (6) @(posedge clk);
      #10;
      ext_capture = 6'h0;
      acc(0, 0, 12'h848, 32'h0);
      chk(rd, 32'(e));
    end
    // ==========================================================
    // Partition and group filters, enable
    filt_partition_id = 64'h42;
    filt_monitoring_group = 32'h9;
    acc(1, 0, 12'h818, 32'h8001_0000);
    acc(1, 0, 12'h840, 32'h0);
    alloc(16'h41, 8'h0, 8'h05);
    alloc(16'h42, 8'h0, 8'h07);
    acc(0, 0, 12'h840, 32'h0);
    chk(rd, 32'h7);
    acc(1, 0, 12'h818, 32'h8003_0000);
    alloc(16'h42, 8'h08, 8'h05);
    alloc(16'h42, 8'h09, 8'h02);
    acc(0, 0, 12'h840, 32'h0);
    chk(rd, 32'h9);
    acc(1, 0, 12'h818, 32'h8002_0000);
    alloc(16'h41, 8'h09, 8'h05);
    alloc(16'h42, 8'h09, 8'h03);
    acc(0, 0, 12'h840, 32'h0);
    chk(rd, 32'hc);
    acc(1, 0, 12'h818, 32'h0003_0000);
    alloc(16'h42, 8'h09, 8'h02);
    acc(0, 0, 12'h840, 32'h0);
    chk(rd, 32'hc);
    // ==========================================================
    // Wrap without hold, snapshot on wrap with not-ready
    acc(1, 0, 12'h818, 32'h8080_0000);
    acc(1, 0, 12'h840, 32'h7fff_fffe);
    not_ready_flag = 4'h1;
    alloc(16'h0, 8'h0, 8'h05);
    alloc(16'h0, 8'h0, 8'h02);
    acc(0, 0, 12'h840, 32'h0);
    chk(rd, 32'h8000_0005);
    acc(0, 0, 12'h848, 32'h0);
    chk(rd, 32'h8000_0003);
    acc(0, 0, 12'h818, 32'h0);
    chk(rd, 32'h8480_0000);
    not_ready_flag = 4'h0;
    // ==========================================================
    // Trigger as wrap on a non-secure monitor
    irqs = 0;
    acc(1, 1, 12'h818, 32'hf304_0000);
    acc(1, 1, 12'h840, 32'h11);
    acc(1, 0, 12'h808, 32'h1);
    acc(0, 1, 12'h848, 32'h0);
    chk(rd, 32'h0);
    acc(1, 0, 12'h808, 32'h3);
    alloc(16'h0, 8'h0, 8'h04);
    acc(0, 1, 12'h848, 32'h0);
    chk(rd, 32'h11);
    acc(0, 1, 12'h840, 32'h0);
    chk(rd, 32'h11);
    acc(1, 1, 12'h840, 32'h22);
    acc(0, 1, 12'h818, 32'h0);
    chk(rd, 32'hf304_0000);
    acc(1, 1, 12'h808, 32'h1);
    acc(0, 1, 12'h848, 32'h0);
    chk(rd, 32'h22);
    acc(0, 1, 12'h818, 32'h0);
    chk(rd, 32'hf704_0000);
    chk(irqs, 2);
    // ==========================================================
    // Reset in mid-run clears the control register
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #10;
    resetn = 1'b1;
    acc(0, 0, 12'h818, 32'h0);
    chk(rd, 32'h0);
    end_of_test;
  end
endmodule // tb_top
